/* shared/mcs_pkg.sv */
`default_nettype none
package mcs_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses on the APB)
   // ----------------------------------------------------------------
   localparam logic [11:0] HIGH_CARRIER_CONTROL_OFFSET = 12'h000;
   localparam logic [11:0] LOW_CARRIER_CONTROL_OFFSET  = 12'h004;
   localparam logic [11:0] CARRIER_STATUS_OFFSET       = 12'h008;

   // ----------------------------------------------------------------
   // Carrier control field layout
   // ----------------------------------------------------------------
   localparam int SELECT_LSB      = 0;
   localparam int SELECT_WIDTH    = 4;
   localparam int UNUSED_BIT      = 4;
   localparam int SYNC_BIT        = 5;
   localparam int INVERT_BIT      = 6;
   localparam int PIN_DISABLE_BIT = 7;
   localparam int CONTROL_WIDTH   = 8;

   localparam logic [7:0] CONTROL_RESET    = 8'h00;
   localparam logic [7:0] CONTROL_WRITE_MASK = 8'hEF;

   // ----------------------------------------------------------------
   // Status register field layout
   // ----------------------------------------------------------------
   localparam int STATUS_MIXED_BIT   = 0;
   localparam int STATUS_HIGH_BIT    = 1;
   localparam int STATUS_MOD_BIT     = 2;
   localparam int STATUS_PENDING_BIT = 3;

   // ----------------------------------------------------------------
   // Carrier source codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SRC_GROUND        = 4'h0;
   localparam logic [3:0] SRC_PIN_ONE       = 4'h1;
   localparam logic [3:0] SRC_PIN_TWO       = 4'h2;
   localparam logic [3:0] SRC_REF_CLOCK     = 4'h3;
   localparam logic [3:0] SRC_CAPTURE_FIRST = 4'h4;
   localparam logic [3:0] SRC_RESERVED_MIN  = 4'h8;
   localparam int         SOURCE_COUNT      = 8;
   localparam int         CAPTURE_COUNT     = 4;

   typedef enum logic {CARRY_HIGH, CARRY_LOW} mcs_phase_t;

   // Picks one bit out of the eight source lines; reserved codes give low.
   function automatic logic pickSource(input logic [3:0] sel, input logic [7:0] sources);
      if (sel >= SRC_RESERVED_MIN)
         pickSource = 1'b0;
      else
         pickSource = sources[sel[2:0]];
   endfunction

   // True when the code names the given capture unit.
   function automatic logic namesCaptureUnit(input logic [3:0] sel, input logic [1:0] unit);
      namesCaptureUnit = (sel == (SRC_CAPTURE_FIRST | {2'b00, unit}));
   endfunction

endpackage
`default_nettype wire

/* shared/mcs_carrier_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface mcs_carrier_if;
   logic carrier;
   logic syncEnable;

   modport source
   (
      output carrier,
      output syncEnable
   );

   modport sink
   (
      input carrier,
      input syncEnable
   );
endinterface
`default_nettype wire

/* src/mcs_carrier_condition.sv */
`timescale 1ns/100ps
`default_nettype none
module mcs_carrier_condition
(
   input  wire logic [7:0] sources,
   input  wire logic [7:0] control,
   mcs_carrier_if.source   out
);

   // ----------------------------------------------------------------
   // Source pick and polarity
   // ----------------------------------------------------------------
   // Reserved codes connect nothing, so the output is then a steady level equal to the invert bit.
   always_comb
   begin
      out.carrier = mcs_pkg::pickSource(control[mcs_pkg::SELECT_LSB +: mcs_pkg::SELECT_WIDTH],
                                        sources)
                    ^ control[mcs_pkg::INVERT_BIT];
      out.syncEnable = control[mcs_pkg::SYNC_BIT];
   end

endmodule
`default_nettype wire

/* src/mcs_carrier_mixer.sv */
`timescale 1ns/100ps
`default_nettype none
module mcs_carrier_mixer
(
   input  wire logic     clk,
   input  wire logic     rstn,
   input  wire logic     modulator,
   mcs_carrier_if.sink   high,
   mcs_carrier_if.sink   low,
   output logic          mixed_reg,
   output logic          highActive_reg,
   output logic          pending_reg
);

   mcs_pkg::mcs_phase_t phase_reg;
   mcs_pkg::mcs_phase_t phase_next;
   logic                highPrev_reg;
   logic                lowPrev_reg;
   logic                highFall;
   logic                lowFall;

   assign highFall = highPrev_reg & ~high.carrier;
   assign lowFall  = lowPrev_reg & ~low.carrier;

   // ----------------------------------------------------------------
   // Carrier hand-over
   // ----------------------------------------------------------------
   always_comb
   begin
      case (phase_reg)
         mcs_pkg::CARRY_HIGH:
            if (!modulator && (!high.syncEnable || highFall))
               phase_next = mcs_pkg::CARRY_LOW;
            else
               phase_next = mcs_pkg::CARRY_HIGH;
         mcs_pkg::CARRY_LOW:
            if (modulator && (!low.syncEnable || lowFall))
               phase_next = mcs_pkg::CARRY_HIGH;
            else
               phase_next = mcs_pkg::CARRY_LOW;
         default:
            phase_next = mcs_pkg::CARRY_LOW;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         phase_reg    <= mcs_pkg::CARRY_LOW;
         highPrev_reg <= 1'b0;
         lowPrev_reg  <= 1'b0;
      end
      else
      begin
         phase_reg    <= phase_next;
         highPrev_reg <= high.carrier;
         lowPrev_reg  <= low.carrier;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mixed_reg      <= 1'b0;
         highActive_reg <= 1'b0;
         pending_reg    <= 1'b0;
      end
      else
      begin
         mixed_reg      <= (phase_next == mcs_pkg::CARRY_HIGH) ? high.carrier
                                                               : low.carrier;
         highActive_reg <= (phase_next == mcs_pkg::CARRY_HIGH);
         pending_reg    <= (phase_next == mcs_pkg::CARRY_HIGH) ? ~modulator : modulator;
      end
   end

endmodule
`default_nettype wire

/* src/mcs_modulator_carrier_select.sv */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module mcs_modulator_carrier_select
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic              carrierInputPinOne,
   input  wire logic              carrierInputPinTwo,
   input  wire logic              referenceClock,
   input  wire logic              modulatorIn,
   input  wire logic [3:0]        captureUnitPwm,
   output logic                   modulatedOutputValue,
   output logic [3:0]             captureUnitPinDisable
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (ADDR_W < 4 || ADDR_W > 32)
      begin : gBadAddr
         $error("ADDR_W must lie between 4 and 32.");
      end
      if (mcs_pkg::SOURCE_COUNT != 8 || mcs_pkg::CAPTURE_COUNT != 4)
      begin : gBadSources
         $error("The source table needs four fixed lines and four capture units.");
      end
      if (mcs_pkg::SELECT_WIDTH != 4 || mcs_pkg::CONTROL_WIDTH != 8)
      begin : gBadLayout
         $error("Control words must be eight bits with a four-bit select.");
      end
   endgenerate

   // Address bits above the twelfth take no part in decoding, so a wider
   // bus sees the registers repeated every four kilobytes.
   localparam int DECODE_W = (ADDR_W < 12) ? ADDR_W : 12;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Clears the unimplemented bit, so it is neither stored nor seen.
   function automatic logic [7:0] keepImplemented(input logic [7:0] value);
      keepImplemented = value & mcs_pkg::CONTROL_WRITE_MASK;
   endfunction

   // One-hot mask of the capture unit that a control word detaches.
   function automatic logic [3:0] detachMask(input logic [7:0] control);
      detachMask = 4'h0;
      for (int k = 0; k < mcs_pkg::CAPTURE_COUNT; k++)
      begin
         detachMask[k] = control[mcs_pkg::PIN_DISABLE_BIT] &&
                         mcs_pkg::namesCaptureUnit(control[3:0], 2'(k));
      end
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]  highControl_reg;
   logic [7:0]  lowControl_reg;
   logic [3:0]  sync1_reg;
   logic [3:0]  sync2_reg;
   logic        pready_reg;
   logic [31:0] prdata_reg;
   logic        pslverr_reg;
   logic [3:0]  pinDisable_reg;
   logic [3:0]  pinDisable_next;
   logic [7:0]  sources;
   logic        setupPhase;
   logic        writeCommit;
   logic        hitHigh;
   logic        hitLow;
   logic        hitStatus;
   logic [31:0] readValue;
   logic        mixed_reg;
   logic        highActive_reg;
   logic        pending_reg;
   logic [11:0] addr12;
   logic        mapped;
   logic [31:0] statusWord;
   logic        pinOneSync;
   logic        pinTwoSync;
   logic        refClockSync;
   logic        modulatorSync;

   mcs_carrier_if highCarrier ();
   mcs_carrier_if lowCarrier ();

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Pins and the reference clock are asynchronous to clk, so each goes
   // through two flops; the capture unit outputs share clk and need none.
   // A reference clock faster than half of clk will alias here.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end
      else
      begin
         sync1_reg <= {modulatorIn, referenceClock, carrierInputPinTwo, carrierInputPinOne};
         sync2_reg <= sync1_reg;
      end
   end

   // Only these names are read downstream; the first stage stays private.
   assign pinOneSync    = sync2_reg[0];
   assign pinTwoSync    = sync2_reg[1];
   assign refClockSync  = sync2_reg[2];
   assign modulatorSync = sync2_reg[3];

   always_comb
   begin
      sources = 8'h00;
      sources[mcs_pkg::SRC_GROUND[2:0]]    = 1'b0;
      sources[mcs_pkg::SRC_PIN_ONE[2:0]]   = pinOneSync;
      sources[mcs_pkg::SRC_PIN_TWO[2:0]]   = pinTwoSync;
      sources[mcs_pkg::SRC_REF_CLOCK[2:0]] = refClockSync;
      sources[mcs_pkg::SRC_CAPTURE_FIRST[2:0] +: mcs_pkg::CAPTURE_COUNT] = captureUnitPwm;
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   // Every access completes with no wait state: the answer is prepared
   // during the setup cycle and held in flops for the access cycle. A new
   // setup may follow an access at once, since nothing waits on the bus.
   always_comb
   begin
      addr12 = 12'h000;
      addr12[DECODE_W-1:0] = paddr[DECODE_W-1:0];
   end

   assign setupPhase  = psel & ~penable;
   assign hitHigh     = (addr12 == mcs_pkg::HIGH_CARRIER_CONTROL_OFFSET);
   assign hitLow      = (addr12 == mcs_pkg::LOW_CARRIER_CONTROL_OFFSET);
   assign hitStatus   = (addr12 == mcs_pkg::CARRIER_STATUS_OFFSET);
   assign writeCommit = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   assign mapped      = hitHigh | hitLow | (hitStatus & ~pwrite);

   // The status word is a snapshot taken in the setup cycle; a carrier far
   // faster than the bus will have moved on by the time software reads it.
   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[mcs_pkg::STATUS_MIXED_BIT]   = mixed_reg;
      statusWord[mcs_pkg::STATUS_HIGH_BIT]    = highActive_reg;
      statusWord[mcs_pkg::STATUS_MOD_BIT]     = modulatorSync;
      statusWord[mcs_pkg::STATUS_PENDING_BIT] = pending_reg;
   end

   always_comb
   begin
      readValue = 32'h0000_0000;
      if (hitHigh)
         readValue[7:0] = keepImplemented(highControl_reg);
      else if (hitLow)
         readValue[7:0] = keepImplemented(lowControl_reg);
      else if (hitStatus)
         readValue = statusWord;
   end

   // Each response flop falls back to zero outside the access cycle, so a
   // stale answer never lingers on the bus.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pready_reg <= 1'b0;
      else
         pready_reg <= setupPhase;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         prdata_reg <= 32'h0000_0000;
      else if (setupPhase && !pwrite)
         prdata_reg <= readValue;
      else
         prdata_reg <= 32'h0000_0000;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pslverr_reg <= 1'b0;
      else if (setupPhase)
         pslverr_reg <= ~mapped;
      else
         pslverr_reg <= 1'b0;
   end

   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------------------------------
   // Carrier control registers
   // ----------------------------------------------------------------
   // Only the power-on reset reaches these; no other reset source exists
   // in this block, so nothing else can disturb the stored settings.
   // They clear to zero rather than stay unknown, so a fresh part never
   // mixes a random carrier before software has set it up.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         highControl_reg <= mcs_pkg::CONTROL_RESET;
      else if (writeCommit && hitHigh)
         highControl_reg <= keepImplemented(pwdata[7:0]);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         lowControl_reg <= mcs_pkg::CONTROL_RESET;
      else if (writeCommit && hitLow)
         lowControl_reg <= keepImplemented(pwdata[7:0]);
   end

   // ----------------------------------------------------------------
   // Carrier conditioning and mixing
   // ----------------------------------------------------------------
   mcs_carrier_condition uHighCondition
   (
      .sources (sources),
      .control (highControl_reg),
      .out     (highCarrier)
   );

   mcs_carrier_condition uLowCondition
   (
      .sources (sources),
      .control (lowControl_reg),
      .out     (lowCarrier)
   );

   // The modulator passes the same two flops as the carrier pins, so its
   // edges keep their place relative to the pin carriers.
   mcs_carrier_mixer uMixer
   (
      .clk            (clk),
      .rstn           (rstn),
      .modulator      (modulatorSync),
      .high           (highCarrier),
      .low            (lowCarrier),
      .mixed_reg      (mixed_reg),
      .highActive_reg (highActive_reg),
      .pending_reg    (pending_reg)
   );

   assign modulatedOutputValue = mixed_reg;

   // ----------------------------------------------------------------
   // Capture unit pin release
   // ----------------------------------------------------------------
   // A capture unit loses its own pin only while it is the chosen carrier
   // of a register whose disable bit is set; other units keep their pins.
   always_comb
   begin
      pinDisable_next = 4'h0;
      pinDisable_next = pinDisable_next | detachMask(highControl_reg);
      pinDisable_next = pinDisable_next | detachMask(lowControl_reg);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pinDisable_reg <= 4'h0;
      else
         pinDisable_reg <= pinDisable_next;
   end

   assign captureUnitPinDisable = pinDisable_reg;

endmodule
`default_nettype wire

/* tb/mcs_carrier_source_model.sv */
`timescale 1ns/100ps
`default_nettype none
module mcs_carrier_source_model
(
   input  wire logic       clk,
   input  wire logic       run,
   input  wire logic [2:0] level,
   output logic            pinOne,
   output logic            pinTwo,
   output logic            refClock
);
   // ------------------------------------------------
   // Carrier sources
   // ------------------------------------------------
   // Parked pins hold the bench's level, so the two-flop delay cannot blur a check.
   logic [2:0] cnt_reg = 3'h0;
   always @(posedge clk)
      cnt_reg <= cnt_reg + 3'h1;
   assign pinOne   = run ? cnt_reg[1] : level[0];
   assign pinTwo   = run ? cnt_reg[2] : level[1];
   assign refClock = run ? cnt_reg[0] : level[2];
endmodule
`default_nettype wire

/* tb/mcs_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module mcs_monitor
#(
   parameter int ADDR_W = 12
)
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   input wire logic              carrierInputPinOne,
   input wire logic              carrierInputPinTwo,
   input wire logic              referenceClock,
   input wire logic              modulatorIn,
   input wire logic [3:0]        captureUnitPwm,
   input wire logic              modulatedOutputValue,
   input wire logic [3:0]        captureUnitPinDisable
);
   // ------------------------------------------------
   // Shadow registers and settling counters
   // ------------------------------------------------
   // Counters saturate, so a long quiet stretch never wraps into a false trigger.
   logic [7:0] hiCtl_reg;
   logic [7:0] loCtl_reg;
   logic [3:0] pwmQ_reg;
   logic [3:0] cfgCnt_reg;
   logic [3:0] modHi_reg;
   logic [3:0] modLo_reg;
   logic       commit;
   logic       settled;
   logic       noSync;
   assign commit  = psel && penable && pready && pwrite && !pslverr;
   assign settled = cfgCnt_reg > 4'h4;
   assign noSync  = !hiCtl_reg[5] && !loCtl_reg[5];

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hiCtl_reg <= 8'h00;
         loCtl_reg <= 8'h00;
      end
      else if (commit && paddr[2])
         loCtl_reg <= pwdata[7:0] & 8'hEF;
      else if (commit)
         hiCtl_reg <= pwdata[7:0] & 8'hEF;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfgCnt_reg <= 4'h0;
         modHi_reg  <= 4'h0;
         modLo_reg  <= 4'h0;
         pwmQ_reg   <= 4'h0;
      end
      else
      begin
         cfgCnt_reg <= commit ? 4'h0 : cfgCnt_reg + {3'h0, ~&cfgCnt_reg};
         modHi_reg  <= modulatorIn ? modHi_reg + {3'h0, ~&modHi_reg} : 4'h0;
         modLo_reg  <= modulatorIn ? 4'h0 : modLo_reg + {3'h0, ~&modLo_reg};
         pwmQ_reg   <= captureUnitPwm;
      end
   end

   // ------------------------------------------------
   // Assertions
   // ------------------------------------------------
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rstn);

   bit_four_zero_a: assert property (pready && !pwrite && !pslverr |-> !prdata[4])
      else $error("bit four read back as one");
   high_pin_off_a: assert property (cfgCnt_reg > 4'h2 && hiCtl_reg[7] && hiCtl_reg[3:2] == 2'b01
      |-> captureUnitPinDisable[hiCtl_reg[1:0]]) else $error("high unit pin not detached");
   low_pin_off_a: assert property (cfgCnt_reg > 4'h2 && loCtl_reg[7] && loCtl_reg[3:2] == 2'b01
      |-> captureUnitPinDisable[loCtl_reg[1:0]]) else $error("low unit pin not detached");
   high_capture_a: assert property (settled && noSync && modHi_reg > 4'h4 && hiCtl_reg[3:2] == 2'b01
      |-> modulatedOutputValue == (pwmQ_reg[hiCtl_reg[1:0]] ^ hiCtl_reg[6]))
      else $error("high carrier source wrong");
   low_capture_a: assert property (settled && noSync && modLo_reg > 4'h4 && loCtl_reg[3:2] == 2'b01
      |-> modulatedOutputValue == (pwmQ_reg[loCtl_reg[1:0]] ^ loCtl_reg[6]))
      else $error("low carrier source wrong");
   high_reserved_a: assert property (settled && noSync && modHi_reg > 4'h4 && hiCtl_reg[3]
      |-> modulatedOutputValue == hiCtl_reg[6]) else $error("reserved high code not empty");
   low_reserved_a: assert property (settled && noSync && modLo_reg > 4'h4 && loCtl_reg[3]
      |-> modulatedOutputValue == loCtl_reg[6]) else $error("reserved low code not empty");
   high_leave_a: assert property (settled && noSync && $fell(modulatorIn) && loCtl_reg[3:0] == 4'h0
      |-> ##4 (modulatedOutputValue == loCtl_reg[6]) [*3]) else $error("late leave of high");
   low_leave_a: assert property (settled && noSync && $rose(modulatorIn) && hiCtl_reg[3:0] == 4'h0
      |-> ##4 (modulatedOutputValue == hiCtl_reg[6]) [*3]) else $error("late leave of low");
endmodule

bind mcs_modulator_carrier_select mcs_monitor #(.ADDR_W(ADDR_W)) mon_u
(
   .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
   .carrierInputPinOne, .carrierInputPinTwo, .referenceClock, .modulatorIn,
   .captureUnitPwm, .modulatedOutputValue, .captureUnitPinDisable
);
`default_nettype wire

/* tb/tb_modulator_carrier_select.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_modulator_carrier_select;
   logic        clk;
   logic        rstn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        pinOne;
   logic        pinTwo;
   logic        refClock;
   logic        modIn;
   logic [3:0]  pwm;
   logic        outVal;
   logic [3:0]  pinDis;
   logic        run;
   logic [2:0]  level;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  ctl;
   logic [3:0]  p;
   integer      seed;
   integer      fails;
   integer      tests_run;

   mcs_modulator_carrier_select dut_u
   (
      .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .carrierInputPinOne(pinOne), .carrierInputPinTwo(pinTwo), .referenceClock(refClock),
      .modulatorIn(modIn), .captureUnitPwm(pwm), .modulatedOutputValue(outVal),
      .captureUnitPinDisable(pinDis)
   );

   mcs_carrier_source_model src_u
   (
      .clk(clk), .run(run), .level(level), .pinOne(pinOne), .pinTwo(pinTwo), .refClock(refClock)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------
   // Reference model and bus tasks
   // ------------------------------------------------
   // Reserved codes select nothing; the invert bit still applies afterwards.
   function automatic logic expCar(input logic [7:0] k, input logic [3:0] q);
      logic [7:0] srcs;
      srcs = {q, level[2], level[1], level[0], 1'b0};
      return (k[3] ? 1'b0 : srcs[k[2:0]]) ^ k[6];
   endfunction

   function automatic logic [3:0] expPd(input logic [7:0] k);
      return (k[7] && k[3:2] == 2'b01) ? 4'h1 << k[1:0] : 4'h0;
   endfunction

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         fails++;
         close_out();
      end
   endtask

   // A held carrier proves the wait; dropping it must release the switch.
   task automatic syncCase(input logic lo, input logic sy);
      logic [7:0] k;
      logic [3:0] pw;
      k  = {2'b00, sy, 1'b0, 2'b01, 1'b0, lo};
      pw = lo ? 4'h2 : 4'h1;
      apb(1'b1, 12'h000, lo ? 32'h0 : {24'h0, k});
      apb(1'b1, 12'h004, lo ? {24'h0, k} : 32'h0);
      pwm   <= pw;
      modIn <= !lo;
      cyc(8);
      @(negedge clk);
      check({31'h0, outVal}, 32'h1);
      @(posedge clk);
      modIn <= lo;
      cyc(10);
      @(negedge clk);
      check({31'h0, outVal}, {31'h0, sy});
      apb(1'b0, 12'h008, 32'h0);
      check(rd, {28'h0, sy, lo, lo ^ sy, sy});
      @(posedge clk);
      pwm <= 4'h0;
      cyc(4);
      pwm <= pw;
      cyc(4);
      @(negedge clk);
      check({31'h0, outVal}, 32'h0);
      @(posedge clk);
   endtask

   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial
   begin
      seed      = 32'h684ce57a;
      fails     = 0;
      tests_run = 0;
      rstn      = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0;
      modIn     = 1'b0;
      pwm       = 4'h0;
      run       = 1'b1;
      level     = 3'h0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      apb(1'b1, 12'h008, 32'hFF);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h00C, 32'h0);
      check({31'h0, err}, 32'h1);
      for (int a = 0; a < 8; a += 4)
      begin
         apb(1'b0, 12'(a), 32'h0);
         check(rd, 32'h0);
      end
      run <= 1'b0;
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 16; c++)
         begin
            ctl = (8'($random(seed)) & 8'hD0) | 8'(c);
            apb(1'b1, s ? 12'h004 : 12'h000, {24'h0, ctl});
            apb(1'b1, s ? 12'h000 : 12'h004, 32'h0);
            apb(1'b0, s ? 12'h004 : 12'h000, 32'h0);
            check(rd, {24'h0, ctl & 8'hEF});
            modIn <= (s == 0);
            level <= 3'($random(seed));
            cyc(6);
            repeat (4)
            begin
               p = pwm;
               pwm <= 4'($random(seed));
               @(negedge clk);
               check({31'h0, outVal}, {31'h0, expCar(ctl, p)});
               check({28'h0, pinDis}, {28'h0, expPd(ctl)});
               @(posedge clk);
            end
         end
      for (int s = 0; s < 4; s++)
         syncCase(s[1], !s[0]);
      close_out();
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
